/* File: verilog/monitor_pin_pkg.sv */
package monitor_pin_pkg;
	localparam int          ADDR_W           = 8;
	localparam int          DATA_W           = 8;
	// Register offsets
	localparam logic [7:0]  PIN_C_ADDR       = 8'h12;
	localparam logic [7:0]  PIN_D_ADDR       = 8'h13;
	localparam logic [7:0]  QUICK_ADDR       = 8'h14;
	localparam logic [7:0]  DRIVE_CHAN_ADDR  = 8'h16;
	// Reset values
	localparam logic [7:0]  PIN_C_RESET      = 8'h42;
	localparam logic [7:0]  PIN_D_RESET      = 8'hfc;
	localparam logic [7:0]  QUICK_RESET      = 8'h01;
	localparam logic [7:0]  DRIVE_CHAN_RESET = 8'h00;
	// Writable bits; the rest are reserved and read as zero
	localparam logic [7:0]  PIN_C_WMASK      = 8'hfe;
	localparam logic [7:0]  PIN_D_WMASK      = 8'hfc;
	localparam logic [7:0]  QUICK_WMASK      = 8'h1f;
	localparam logic [7:0]  DRIVE_CHAN_WMASK = 8'hff;
	// Field positions, pin function select c
	localparam int          INTRUSION_BIT    = 1;
	localparam int          PIN26_LSB        = 2;
	localparam int          PIN25_LSB        = 4;
	localparam int          PIN24_LSB        = 6;
	// Field positions, pin function select d
	localparam int          PIN32_BIT        = 2;
	localparam int          PIN31_BIT        = 3;
	localparam int          PIN29_LSB        = 4;
	localparam int          PIN28_LSB        = 6;
	// Field positions, quick setup and drive/channel control
	localparam int          QUICK_LSB        = 0;
	localparam int          QUICK_W          = 5;
	localparam int          DRIVE_A_BIT      = 0;
	localparam int          DRIVE_B_BIT      = 1;
	localparam int          SINGLE_BIT       = 2;
	localparam int          CHAN_LSB         = 3;
	localparam int          CHAN_W           = 5;
	// Two-bit pin field codes
	localparam logic [1:0]  SEL_00           = 2'h0;
	localparam logic [1:0]  SEL_01           = 2'h1;
	// Single conversion channel codes
	localparam logic [4:0]  CH_PIN26         = 5'h00;
	localparam logic [4:0]  CH_REMOTE1       = 5'h01;
	localparam logic [4:0]  CH_REMOTE2       = 5'h02;
	localparam logic [4:0]  CH_REMOTE3       = 5'h03;
	localparam logic [4:0]  CH_LOCAL         = 5'h04;
	localparam logic [4:0]  CH_FIRST_VOLT    = 5'h05;
	localparam logic [4:0]  CH_1V5_A         = 5'h10;
	localparam logic [4:0]  CH_1V5_B         = 5'h11;
endpackage

/* File: verilog/monitor_pin_config.sv */
// Summary of operation
// RULE_01: Bit 1 of select c: clear gives fan full-speed out, set gives intrusion.
// RULE_02: Pin 26 field: zero battery, one 1.2 V rail, else regulator-hot b.
// RULE_03: Pin 25 field: 00 3.3 V, 01 1.2 V rail, 10/11 regulator-hot a.
// RULE_04: Pin 24 field: core voltage b, 2.5 V default, 1.8 V, 1.5 V.
// RULE_05: Pin 32 bit: general io six or fan drive b; voltage-ID bit five.
// RULE_06: Pin 31 bit: general io five or fan drive a; voltage-ID bit four.
// RULE_07: Pin 29 field: io eight, 1.5 V pair, or thermal alarm b.
// RULE_08: Pin 28 field: io seven, 1.5 V pair, or thermal alarm a.
// RULE_09: 1.5 V monitoring only when both paired fields select it.
// RULE_10: Quick setup bits 0..4 enable options one to five; upper bits reserved.
// RULE_11: Control bits 0 and 1 enable special drive on io five and six.
// RULE_12: Control bit 2 restricts conversion to the selected single channel.
// RULE_13: Channel codes 0..4: pin 26, remote 1..3, local temperature.
// RULE_14: Codes from 00101 are voltages; 10000 and 10001 the 1.5 V channels.
// RULE_15: Reset to default values by power-on and soft reset; lock blocks writes.
// RULE_16: Bit 0 of select c and bits 1:0 of select d are reserved.
// RULE_17: Voltage-ID enable overrides the pin functions of shared pins.
// RULE_18: Reserved bits ignore writes and read back as zero.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module monitor_pin_config
	import monitor_pin_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              soft_reset,
	input  wire logic              reg_lock,
	input  wire logic              voltage_id_enable,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              wr_strobe,
	input  wire logic              rd_strobe,
	output logic      [DATA_W-1:0] rdata,
	output logic                   fan_full_speed_out_sel,
	output logic                   chassis_intrusion_sel,
	output logic                   battery_voltage_in_sel,
	output logic                   rail_1v2_b_sel,
	output logic                   regulator_hot_in_b_sel,
	output logic                   monitor_3v3_sel,
	output logic                   rail_1v2_a_sel,
	output logic                   regulator_hot_in_a_sel,
	output logic      [3:0]        pin24_voltage_sel,
	output logic                   general_io_six_sel,
	output logic                   fan_drive_out_b_sel,
	output logic                   voltage_id_bit_five_sel,
	output logic                   general_io_five_sel,
	output logic                   fan_drive_out_a_sel,
	output logic                   voltage_id_bit_four_sel,
	output logic                   general_io_eight_sel,
	output logic                   thermal_alarm_b_sel,
	output logic                   general_io_seven_sel,
	output logic                   thermal_alarm_a_sel,
	output logic                   voltage_id_bit_six_sel,
	output logic                   monitor_1v5_active,
	output logic                   pair_conflict,
	output logic      [QUICK_W-1:0] quick_option_en,
	output logic                   special_drive_enable_a,
	output logic                   special_drive_enable_b,
	output logic                   single_channel_mode,
	output logic      [CHAN_W-1:0] conv_channel,
	output logic                   conv_channel_voltage,
	output logic                   conv_channel_valid
);

	typedef struct packed {
		logic [7:0]         pin_c;
		logic [7:0]         pin_d;
		logic [7:0]         quick;
		logic [7:0]         drive_chan;
		logic [7:0]         rdata;
		logic               fan_full;
		logic               intrusion;
		logic               batt;
		logic               rail_b;
		logic               vrhot_b;
		logic               mon_3v3;
		logic               rail_a;
		logic               vrhot_a;
		logic [3:0]         pin24;
		logic               io6;
		logic               drive_b;
		logic               voltage_id_bit_five;
		logic               io5;
		logic               drive_a;
		logic               voltage_id_bit_four;
		logic               io8;
		logic               therm_b;
		logic               io7;
		logic               therm_a;
		logic               voltage_id_bit_six;
		logic               mon_1v5;
		logic               conflict;
		logic [QUICK_W-1:0] easy;
		logic               edo_a;
		logic               edo_b;
		logic               single;
		logic [CHAN_W-1:0]  chan;
		logic               chan_volt;
		logic               chan_ok;
	} state_s;

	state_s state_q;
	state_s state_d;

	logic       wr_ok;
	logic [1:0] f26;
	logic [1:0] f25;
	logic [1:0] f24;
	logic [1:0] f29;
	logic [1:0] f28;

	always_comb
	begin
		state_d = state_q;
		// A locked register file still answers reads
		wr_ok = wr_strobe && !reg_lock;
		// RULE_15: reset and lock
		if (soft_reset)
		begin
			state_d.pin_c      = PIN_C_RESET;
			state_d.pin_d      = PIN_D_RESET;
			state_d.quick      = QUICK_RESET;
			state_d.drive_chan = DRIVE_CHAN_RESET;
		end
		else if (wr_ok)
		begin
			// RULE_16: reserved bits held
			// RULE_18: reserved bits masked
			unique case (addr)
				PIN_C_ADDR:      state_d.pin_c      = wdata & PIN_C_WMASK;
				PIN_D_ADDR:      state_d.pin_d      = wdata & PIN_D_WMASK;
				QUICK_ADDR:      state_d.quick      = wdata & QUICK_WMASK;
				DRIVE_CHAN_ADDR: state_d.drive_chan = wdata & DRIVE_CHAN_WMASK;
				default:         ;
			endcase
		end
		// Read data stand for one cycle only; unmapped offsets read zero
		state_d.rdata = '0;
		if (rd_strobe)
		begin
			unique case (addr)
				PIN_C_ADDR:      state_d.rdata = state_q.pin_c;
				PIN_D_ADDR:      state_d.rdata = state_q.pin_d;
				QUICK_ADDR:      state_d.rdata = state_q.quick;
				DRIVE_CHAN_ADDR: state_d.rdata = state_q.drive_chan;
				default:         state_d.rdata = '0;
			endcase
		end
		// Decode from the next register values so the selects track writes
		f26 = state_d.pin_c[PIN26_LSB +: 2];
		f25 = state_d.pin_c[PIN25_LSB +: 2];
		f24 = state_d.pin_c[PIN24_LSB +: 2];
		f29 = state_d.pin_d[PIN29_LSB +: 2];
		f28 = state_d.pin_d[PIN28_LSB +: 2];
		// RULE_01: fan or intrusion
		state_d.intrusion = state_d.pin_c[INTRUSION_BIT];
		state_d.fan_full  = !state_d.pin_c[INTRUSION_BIT];
		// RULE_02: pin 26 decode
		state_d.batt    = (f26 == SEL_00);
		state_d.rail_b  = (f26 == SEL_01);
		state_d.vrhot_b = f26[1];
		// RULE_03: pin 25 decode
		state_d.mon_3v3 = (f25 == SEL_00);
		state_d.rail_a  = (f25 == SEL_01);
		state_d.vrhot_a = f25[1];
		// RULE_04: pin 24 one-hot
		state_d.pin24 = 4'h1 << f24;
		// RULE_05: pin 32 decode
		state_d.voltage_id_bit_five    = voltage_id_enable;
		state_d.io6     = !voltage_id_enable && !state_d.pin_d[PIN32_BIT];
		state_d.drive_b = !voltage_id_enable && state_d.pin_d[PIN32_BIT];
		// RULE_06: pin 31 decode
		state_d.voltage_id_bit_four    = voltage_id_enable;
		state_d.io5     = !voltage_id_enable && !state_d.pin_d[PIN31_BIT];
		state_d.drive_a = !voltage_id_enable && state_d.pin_d[PIN31_BIT];
		// RULE_09: 1.5 V needs both fields and a free pin 28
		state_d.mon_1v5  = (f29 == SEL_01) && (f28 == SEL_01) && !voltage_id_enable;
		state_d.conflict = ((f29 == SEL_01) || (f28 == SEL_01)) && !state_d.mon_1v5;
		// RULE_07: pin 29 decode
		state_d.io8     = (f29 == SEL_00);
		state_d.therm_b = f29[1];
		// RULE_08: pin 28 decode
		// RULE_17: voltage-ID takes pin 28
		state_d.voltage_id_bit_six    = voltage_id_enable;
		state_d.io7     = !voltage_id_enable && (f28 == SEL_00);
		state_d.therm_a = !voltage_id_enable && f28[1];
		// RULE_10: quick setup options
		state_d.easy = state_d.quick[QUICK_LSB +: QUICK_W];
		// RULE_11: special drive enables
		state_d.edo_a = state_d.drive_chan[DRIVE_A_BIT];
		state_d.edo_b = state_d.drive_chan[DRIVE_B_BIT];
		// RULE_12: single channel mode
		state_d.single = state_d.drive_chan[SINGLE_BIT];
		// RULE_13: channel code
		state_d.chan = state_d.drive_chan[CHAN_LSB +: CHAN_W];
		// RULE_14: voltage channels and top of the code range
		state_d.chan_volt = (state_d.chan >= CH_FIRST_VOLT) && (state_d.chan <= CH_1V5_B);
		state_d.chan_ok   = (state_d.chan <= CH_1V5_B);
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_q            <= '0;
			state_q.pin_c      <= PIN_C_RESET;
			state_q.pin_d      <= PIN_D_RESET;
			state_q.quick      <= QUICK_RESET;
			state_q.drive_chan <= DRIVE_CHAN_RESET;
			state_q.intrusion  <= 1'b1;
			state_q.batt       <= 1'b1;
			state_q.mon_3v3    <= 1'b1;
			state_q.pin24      <= 4'h2;
			state_q.drive_b    <= 1'b1;
			state_q.drive_a    <= 1'b1;
			state_q.therm_b    <= 1'b1;
			state_q.therm_a    <= 1'b1;
			state_q.easy       <= 5'h01;
			state_q.chan_ok    <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign rdata                   = state_q.rdata;
	assign fan_full_speed_out_sel  = state_q.fan_full;
	assign chassis_intrusion_sel   = state_q.intrusion;
	assign battery_voltage_in_sel  = state_q.batt;
	assign rail_1v2_b_sel          = state_q.rail_b;
	assign regulator_hot_in_b_sel  = state_q.vrhot_b;
	assign monitor_3v3_sel         = state_q.mon_3v3;
	assign rail_1v2_a_sel          = state_q.rail_a;
	assign regulator_hot_in_a_sel  = state_q.vrhot_a;
	assign pin24_voltage_sel       = state_q.pin24;
	assign general_io_six_sel      = state_q.io6;
	assign fan_drive_out_b_sel     = state_q.drive_b;
	assign voltage_id_bit_five_sel = state_q.voltage_id_bit_five;
	assign general_io_five_sel     = state_q.io5;
	assign fan_drive_out_a_sel     = state_q.drive_a;
	assign voltage_id_bit_four_sel = state_q.voltage_id_bit_four;
	assign general_io_eight_sel    = state_q.io8;
	assign thermal_alarm_b_sel     = state_q.therm_b;
	assign general_io_seven_sel    = state_q.io7;
	assign thermal_alarm_a_sel     = state_q.therm_a;
	assign voltage_id_bit_six_sel  = state_q.voltage_id_bit_six;
	assign monitor_1v5_active      = state_q.mon_1v5;
	assign pair_conflict           = state_q.conflict;
	assign quick_option_en         = state_q.easy;
	assign special_drive_enable_a  = state_q.edo_a;
	assign special_drive_enable_b  = state_q.edo_b;
	assign single_channel_mode     = state_q.single;
	assign conv_channel            = state_q.chan;
	assign conv_channel_voltage    = state_q.chan_volt;
	assign conv_channel_valid      = state_q.chan_ok;

	property p_soft_reset;
		@(posedge clk) disable iff (!reset_n)
		soft_reset |=> state_q.pin_c == PIN_C_RESET && state_q.pin_d == PIN_D_RESET
			&& state_q.quick == QUICK_RESET && state_q.drive_chan == DRIVE_CHAN_RESET;
	endproperty
	a_soft_reset: assert property (p_soft_reset) // RULE_15
		else $error("soft reset did not restore registers");

	property p_lock;
		@(posedge clk) disable iff (!reset_n)
		wr_strobe && reg_lock && !soft_reset |=> $stable(state_q.pin_c)
			&& $stable(state_q.pin_d) && $stable(state_q.quick) && $stable(state_q.drive_chan);
	endproperty
	a_lock: assert property (p_lock) // RULE_15
		else $error("locked write changed a register");

	property p_reserved;
		@(posedge clk) disable iff (!reset_n)
		state_q.pin_c[0] == 1'b0 && state_q.pin_d[1:0] == 2'h0 && state_q.quick[7:5] == 3'h0;
	endproperty
	a_reserved: assert property (p_reserved) // RULE_16
		else $error("reserved bit is not zero");

	property p_read_back;
		@(posedge clk) disable iff (!reset_n)
		rd_strobe && addr == PIN_D_ADDR |=> rdata == $past(state_q.pin_d) && rdata[1:0] == 2'h0;
	endproperty
	a_read_back: assert property (p_read_back) // RULE_18
		else $error("read data wrong for select d");

	property p_read_idle;
		@(posedge clk) disable iff (!reset_n)
		!rd_strobe |=> rdata == 8'h00;
	endproperty
	a_read_idle: assert property (p_read_idle) // RULE_18
		else $error("read data outside read cycle");

	property p_fan_write;
		@(posedge clk) disable iff (!reset_n)
		wr_strobe && !reg_lock && !soft_reset && addr == PIN_C_ADDR && !wdata[1]
			|=> fan_full_speed_out_sel && !chassis_intrusion_sel;
	endproperty
	a_fan_write: assert property (p_fan_write) // RULE_01
		else $error("fan full-speed select not taken");

	property p_vrhot_b;
		@(posedge clk) disable iff (!reset_n)
		state_q.pin_c[3] |-> regulator_hot_in_b_sel && !battery_voltage_in_sel && !rail_1v2_b_sel;
	endproperty
	a_vrhot_b: assert property (p_vrhot_b) // RULE_02
		else $error("pin 26 decode wrong");

	property p_pair;
		@(posedge clk) disable iff (!reset_n)
		monitor_1v5_active |-> state_q.pin_d[5:4] == SEL_01 && state_q.pin_d[7:6] == SEL_01
			&& !thermal_alarm_a_sel && !thermal_alarm_b_sel && !pair_conflict;
	endproperty
	a_pair: assert property (p_pair) // RULE_09
		else $error("1.5 V active without both fields");

	property p_vid;
		@(posedge clk) disable iff (!reset_n)
		voltage_id_enable |=> !general_io_five_sel && !fan_drive_out_a_sel && !general_io_six_sel
			&& !fan_drive_out_b_sel && !thermal_alarm_a_sel && !general_io_seven_sel
			&& voltage_id_bit_four_sel && voltage_id_bit_six_sel;
	endproperty
	a_vid: assert property (p_vid) // RULE_17
		else $error("voltage-ID did not override pins");

	property p_chan_write;
		@(posedge clk) disable iff (!reset_n)
		wr_strobe && !reg_lock && !soft_reset && addr == DRIVE_CHAN_ADDR
			|=> conv_channel == $past(wdata[7:3]) && single_channel_mode == $past(wdata[2]);
	endproperty
	a_chan_write: assert property (p_chan_write) // RULE_13
		else $error("channel select not taken");

	property p_chan_range;
		@(posedge clk) disable iff (!reset_n)
		conv_channel == CH_1V5_B || conv_channel == CH_1V5_A |-> conv_channel_valid
			&& conv_channel_voltage;
	endproperty
	a_chan_range: assert property (p_chan_range) // RULE_14
		else $error("1.5 V channel not valid");

	property p_easy;
		@(posedge clk) disable iff (!reset_n)
		wr_strobe && !reg_lock && !soft_reset && addr == QUICK_ADDR
			|=> quick_option_en == $past(wdata[4:0]);
	endproperty
	a_easy: assert property (p_easy) // RULE_10
		else $error("quick setup options not taken");

endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
module testbench
	import monitor_pin_pkg::*;
;
	logic              clk;
	logic              reset_n;
	logic              soft_reset;
	logic              reg_lock;
	logic              voltage_id_enable;
	logic [7:0]        addr;
	logic [7:0]        wdata;
	logic              wr_strobe;
	logic              rd_strobe;
	logic [7:0]        rdata;
	logic              fan_full_speed_out_sel, chassis_intrusion_sel, battery_voltage_in_sel;
	logic              rail_1v2_b_sel, regulator_hot_in_b_sel, monitor_3v3_sel, rail_1v2_a_sel;
	logic              regulator_hot_in_a_sel, general_io_six_sel, fan_drive_out_b_sel;
	logic              voltage_id_bit_five_sel, general_io_five_sel, fan_drive_out_a_sel;
	logic              voltage_id_bit_four_sel, general_io_eight_sel, thermal_alarm_b_sel;
	logic              general_io_seven_sel, thermal_alarm_a_sel, voltage_id_bit_six_sel;
	logic              monitor_1v5_active, pair_conflict, special_drive_enable_a;
	logic              special_drive_enable_b, single_channel_mode;
	logic              conv_channel_voltage, conv_channel_valid;
	logic [3:0]        pin24_voltage_sel;
	logic [4:0]        quick_option_en;
	logic [4:0]        conv_channel;
	logic [11:0]       pc_v;
	logic [12:0]       pd_v;
	logic [9:0]        ch_v;
	int                n_errors;
	int                checks;

	// Decoded outputs grouped per register so one compare covers a whole field set
	assign pc_v = {fan_full_speed_out_sel, chassis_intrusion_sel, battery_voltage_in_sel,
		rail_1v2_b_sel, regulator_hot_in_b_sel, monitor_3v3_sel, rail_1v2_a_sel,
		regulator_hot_in_a_sel, pin24_voltage_sel};
	assign pd_v = {general_io_six_sel, fan_drive_out_b_sel, voltage_id_bit_five_sel,
		general_io_five_sel, fan_drive_out_a_sel, voltage_id_bit_four_sel, general_io_eight_sel,
		thermal_alarm_b_sel, general_io_seven_sel, thermal_alarm_a_sel, voltage_id_bit_six_sel,
		monitor_1v5_active, pair_conflict};
	assign ch_v = {special_drive_enable_a, special_drive_enable_b, single_channel_mode,
		conv_channel, conv_channel_voltage, conv_channel_valid};

	monitor_pin_config i_monitor_pin_config (
		.clk(clk), .reset_n(reset_n), .soft_reset(soft_reset), .reg_lock(reg_lock),
		.voltage_id_enable(voltage_id_enable), .addr(addr), .wdata(wdata),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
		.fan_full_speed_out_sel(fan_full_speed_out_sel),
		.chassis_intrusion_sel(chassis_intrusion_sel),
		.battery_voltage_in_sel(battery_voltage_in_sel), .rail_1v2_b_sel(rail_1v2_b_sel),
		.regulator_hot_in_b_sel(regulator_hot_in_b_sel), .monitor_3v3_sel(monitor_3v3_sel),
		.rail_1v2_a_sel(rail_1v2_a_sel), .regulator_hot_in_a_sel(regulator_hot_in_a_sel),
		.pin24_voltage_sel(pin24_voltage_sel), .general_io_six_sel(general_io_six_sel),
		.fan_drive_out_b_sel(fan_drive_out_b_sel),
		.voltage_id_bit_five_sel(voltage_id_bit_five_sel),
		.general_io_five_sel(general_io_five_sel), .fan_drive_out_a_sel(fan_drive_out_a_sel),
		.voltage_id_bit_four_sel(voltage_id_bit_four_sel),
		.general_io_eight_sel(general_io_eight_sel), .thermal_alarm_b_sel(thermal_alarm_b_sel),
		.general_io_seven_sel(general_io_seven_sel), .thermal_alarm_a_sel(thermal_alarm_a_sel),
		.voltage_id_bit_six_sel(voltage_id_bit_six_sel),
		.monitor_1v5_active(monitor_1v5_active), .pair_conflict(pair_conflict),
		.quick_option_en(quick_option_en), .special_drive_enable_a(special_drive_enable_a),
		.special_drive_enable_b(special_drive_enable_b),
		.single_channel_mode(single_channel_mode), .conv_channel(conv_channel),
		.conv_channel_voltage(conv_channel_voltage), .conv_channel_valid(conv_channel_valid)
	);

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_strobe <= 1'b1;
		addr      <= a;
		wdata     <= d;
		@(posedge clk);
		wr_strobe <= 1'b0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd_strobe <= 1'b1;
		addr      <= a;
		@(posedge clk);
		rd_strobe <= 1'b0;
		#1;
		chk($sformatf("rdata at %h", a), {8'h00, exp}, {8'h00, rdata});
	endtask

	task automatic defaults_check();
		rdchk(PIN_C_ADDR, 8'h42);
		rdchk(PIN_D_ADDR, 8'hfc);
		rdchk(QUICK_ADDR, 8'h01);
		rdchk(DRIVE_CHAN_ADDR, 8'h00);
		chk("pin c decode", {4'h0, 12'b0110_0100_0010}, {4'h0, pc_v});
		chk("pin d decode", {3'h0, 13'b0100_1001_0100_0}, {3'h0, pd_v});
		chk("channel decode", 16'h0001, {6'h00, ch_v});
		chk("quick options", 16'h0001, {11'h000, quick_option_en});
	endtask

	task automatic pin_c_codes();
		logic [1:0] k;
		logic [7:0] v;
		for (int i = 0; i < 4; i++)
		begin
			k = 2'(i);
			v = {k, k, k, k[0], 1'b1};
			wr(PIN_C_ADDR, v);
			chk("pin c decode", {4'h0, ~k[0], k[0], k == 2'd0, k == 2'd1, k[1], k == 2'd0,
				k == 2'd1, k[1], 4'b0001 << k}, {4'h0, pc_v});
			rdchk(PIN_C_ADDR, v & 8'hfe);
		end
	endtask

	task automatic pin_d_codes();
		logic [1:0] k;
		logic [7:0] v;
		for (int i = 0; i < 4; i++)
		begin
			k = 2'(i);
			v = {k, k, k, 2'b11};
			wr(PIN_D_ADDR, v);
			chk("pin d decode", {3'h0, ~k[0], k[0], 1'b0, ~k[1], k[1], 1'b0, k == 2'd0, k[1],
				k == 2'd0, k[1], 1'b0, k == 2'd1, 1'b0}, {3'h0, pd_v});
			rdchk(PIN_D_ADDR, v & 8'hfc);
		end
		// One field at the 1.5 V code, the partner at thermal alarm
		wr(PIN_D_ADDR, 8'hd0);
		chk("pin d half pair", {3'h0, 13'b1001_0000_0100_1}, {3'h0, pd_v});
	endtask

	task automatic vid_override();
		wr(PIN_D_ADDR, 8'hfc);
		@(posedge clk);
		voltage_id_enable <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("vid override", {3'h0, 13'b0010_0101_0010_0}, {3'h0, pd_v});
		wr(PIN_D_ADDR, 8'h5c);
		chk("vid blocks pair", {3'h0, 13'b0010_0100_0010_1}, {3'h0, pd_v});
		@(posedge clk);
		voltage_id_enable <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("pair active", {3'h0, 13'b0100_1000_0001_0}, {3'h0, pd_v});
	endtask

	task automatic quick_and_unmapped();
		wr(QUICK_ADDR, 8'hff);
		rdchk(QUICK_ADDR, 8'h1f);
		chk("quick options", 16'h001f, {11'h000, quick_option_en});
		wr(QUICK_ADDR, 8'h0a);
		chk("quick options", 16'h000a, {11'h000, quick_option_en});
		wr(8'h15, 8'hff);
		rdchk(8'h15, 8'h00);
		rdchk(QUICK_ADDR, 8'h0a);
	endtask

	task automatic channel_codes();
		logic [4:0] c;
		logic [7:0] b;
		for (int i = 0; i < 32; i++)
		begin
			c = 5'(i);
			b = {c, c[2:0]};
			wr(DRIVE_CHAN_ADDR, b);
			chk("channel decode", {6'h00, b[0], b[1], b[2], c, c >= 5'd5 && c <= 5'd17,
				c <= 5'd17}, {6'h00, ch_v});
			rdchk(DRIVE_CHAN_ADDR, b);
		end
	endtask

	// Soft reset under the lock, with a locked write in the same cycle, restores the defaults
	task automatic lock_and_soft_reset();
		wr(PIN_C_ADDR, 8'h00);
		@(posedge clk);
		reg_lock <= 1'b1;
		wr(PIN_C_ADDR, 8'h80);
		rdchk(PIN_C_ADDR, 8'h00);
		@(posedge clk);
		wr_strobe  <= 1'b1;
		addr       <= PIN_C_ADDR;
		wdata      <= 8'h00;
		soft_reset <= 1'b1;
		@(posedge clk);
		wr_strobe  <= 1'b0;
		soft_reset <= 1'b0;
		reg_lock   <= 1'b0;
		rdchk(PIN_C_ADDR, 8'h42);
		rdchk(DRIVE_CHAN_ADDR, 8'h00);
		wr(QUICK_ADDR, 8'h1f);
		@(posedge clk);
		reset_n <= 1'b0;
		#1;
		chk("async reset", 16'h0001, {11'h000, quick_option_en});
		@(posedge clk);
		reset_n <= 1'b1;
		rdchk(PIN_D_ADDR, 8'hfc);
	endtask

	initial
	begin
		n_errors          = 0;
		checks            = 0;
		reset_n           = 1'b0;
		soft_reset        = 1'b0;
		reg_lock          = 1'b0;
		voltage_id_enable = 1'b0;
		addr              = 8'h00;
		wdata             = 8'h00;
		wr_strobe         = 1'b0;
		rd_strobe         = 1'b0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		defaults_check();
		pin_c_codes();
		pin_d_codes();
		vid_override();
		quick_and_unmapped();
		channel_codes();
		lock_and_soft_reset();
		test_done();
	end

	// Whole run needs well under a thousand cycles
	initial
	begin
		#200000;
		n_errors++;
		test_done();
	end
endmodule
